// ===== iacr_control_regs.sv
`timescale 1ns/100ps
// What this block does
// (RULE_01) Bit 4 enables comparator one rising interrupt.
// (RULE_02) Bits 3..0 enable comparator falling interrupts.
// (RULE_03) Control bit 15 selects 32-bit checked frames.
// (RULE_04) Control bit 14 shares channel one thresholds.
// (RULE_05) Bits 7..4 clear per-channel averaging filters.
// (RULE_06) Control bit 3 switches field supply off.
// (RULE_07) Writing bit 2 clears power-on flag.
// (RULE_08) Bit 1 soft-resets registers, self-clearing.
// (RULE_09) Bit 0 hard-resets, supply off, self-clearing.
// (RULE_10) Falling edge sets flag until status read.
// (RULE_11) Interrupt follows any enabled set flag.
// (RULE_12) Fields reset zero; reserved bits read zero.
module iacr_control_regs
	import iacr_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic spiSclk,
	input wire logic spiCsN,
	input wire logic spiMosi,
	output logic spiMisoOut,
	output logic spiMisoEnN,
	input wire logic [3:0] comparatorOut,
	output iacr_ctl_s ctl,
	output logic irq
);

	iacr_main_s s;
	iacr_main_s next_s;
	logic [3:0] riseSeen;
	logic [3:0] fallSeen;
	logic [15:0] statusWord;
	logic [15:0] productWord;

	iacr_edge_flags edgeFlags (
		.clock(clock),
		.reset_n(reset_n),
		.comparatorOut(comparatorOut),
		.clearAll(s.statusClear),
		.riseSeen(riseSeen),
		.fallSeen(fallSeen)
	);

	always_comb begin
		statusWord = 16'h0000;
		statusWord[IACR_STAT_FRAME_ERROR] = s.frameError;
		statusWord[IACR_STAT_CHECK_ERROR] = s.checkError;
		statusWord[IACR_STAT_RISE_LSB +: 4] = riseSeen;
		statusWord[IACR_STAT_FALL_LSB +: 4] = fallSeen;
	end

	always_comb begin
		productWord = 16'h0000;
		productWord[6:0] = IACR_ID_CODE;
		productWord[IACR_ID_POWER_ON_FLAG] = s.powerOnFlag;
	end

	always_comb begin
		logic sclkRise;
		logic sclkFall;
		logic csActive;
		logic csEnd;
		logic [5:0] frameLen;
		logic [5:0] countNext;
		logic [7:0] newCmd;
		logic [15:0] readData;
		logic [23:0] frameBody;
		logic [5:0] wrAddr;
		logic [15:0] wrData;
		sclkRise = 1'b0;
		sclkFall = 1'b0;
		csActive = 1'b0;
		csEnd = 1'b0;
		frameLen = IACR_FRAME_BITS_PLAIN;
		countNext = 6'd0;
		newCmd = 8'h00;
		readData = 16'h0000;
		frameBody = 24'h000000;
		wrAddr = 6'd0;
		wrData = 16'h0000;
		next_s = s;

		// Pins pass two flops; the second stage feeds the logic, and a third stage (sclkSync[2], csPrev) serves edge detection.
		next_s.csSync = {s.csSync[0], spiCsN};
		next_s.csPrev = s.csSync[1];
		next_s.sclkSync = {s.sclkSync[1:0], spiSclk};
		next_s.mosiSync = {s.mosiSync[0], spiMosi};
		sclkRise = s.sclkSync[1] & ~s.sclkSync[2];
		sclkFall = ~s.sclkSync[1] & s.sclkSync[2];
		csActive = ~s.csSync[1];
		csEnd = s.csSync[1] & ~s.csPrev;

		next_s.softPulse = 1'b0;
		next_s.hardPulse = 1'b0;
		next_s.statusClear = 1'b0;

		if (s.control[IACR_CTL_FRAME_CHECK_ENABLE]) begin
			frameLen = IACR_FRAME_BITS_CHECKED; // RULE_03
		end

		if (csActive) begin
			if (sclkRise) begin
				countNext = (s.bitCount == 6'h3f) ? s.bitCount : 6'(s.bitCount + 6'd1);
				next_s.bitCount = countNext;
				next_s.shiftIn = {s.shiftIn[30:0], s.mosiSync[1]};
				if (countNext == IACR_CMD_BITS) begin
					newCmd = {s.shiftIn[6:0], s.mosiSync[1]};
					unique case (newCmd[7:2])
						IACR_ADDR_PRODUCT_ID: readData = productWord;
						IACR_ADDR_IRQ_STATUS: readData = statusWord;
						IACR_ADDR_IRQ_ENABLE: readData = s.irqEnable;
						IACR_ADDR_CONTROL: readData = s.control; // RULE_12
						default: readData = 16'h0000;
					endcase
					// Answer word, followed by its check byte in checked frames only,
					// so that a plain frame leaves the data line low when it ends.
					next_s.shiftOut = {readData, 8'h00};
					if (frameLen == IACR_FRAME_BITS_CHECKED) begin
						next_s.shiftOut[7:0] = iacr_check8({newCmd, readData}); // RULE_03
					end
					if (newCmd[7:2] == IACR_ADDR_IRQ_STATUS && !newCmd[1]) begin
						next_s.statusClear = 1'b1; // RULE_10
					end
				end
			end
			if (sclkFall && s.bitCount > IACR_CMD_BITS) begin
				next_s.shiftOut = {s.shiftOut[22:0], 1'b0};
			end
		end else begin
			next_s.bitCount = 6'd0;
			next_s.shiftOut = 24'h000000;
		end

		// Status flags of this block clear on a status read; errors below still set.
		if (s.statusClear) begin
			next_s.frameError = 1'b0;
			next_s.checkError = 1'b0;
		end

		if (csEnd && s.bitCount != 6'd0) begin
			if (frameLen == IACR_FRAME_BITS_CHECKED) begin
				frameBody = s.shiftIn[31:8];
			end else begin
				frameBody = s.shiftIn[23:0];
			end
			wrAddr = frameBody[23:18];
			wrData = frameBody[15:0];
			if (s.bitCount != frameLen) begin
				next_s.frameError = 1'b1; // RULE_03
			end else if (frameLen == IACR_FRAME_BITS_CHECKED &&
					iacr_check8(frameBody) != s.shiftIn[7:0]) begin
				next_s.checkError = 1'b1; // RULE_03
			end else if (frameBody[17]) begin
				unique case (wrAddr)
					IACR_ADDR_CONTROL: begin
						next_s.control = wrData & IACR_CTL_STORED_MASK; // RULE_12
						if (wrData[IACR_CTL_POWER_ON_FLAG_CLEAR]) begin
							next_s.powerOnFlag = 1'b0; // RULE_07
						end
						if (wrData[IACR_CTL_SOFT_RESET_REQUEST]) begin
							next_s.softPulse = 1'b1; // RULE_08
						end
						if (wrData[IACR_CTL_HARD_RESET_REQUEST]) begin
							next_s.hardPulse = 1'b1; // RULE_09
						end
					end
					IACR_ADDR_IRQ_ENABLE: begin
						next_s.irqEnable = wrData & IACR_IRQ_ENABLE_MASK; // RULE_01
					end
					default: begin
					end
				endcase
			end
		end

		// A reset request returns control, interrupt enables and error flags to their reset values one cycle later; only a hard one sets the power-on flag.
		if (s.softPulse || s.hardPulse) begin
			next_s.control = IACR_CTL_RESET; // RULE_08
			next_s.irqEnable = IACR_IRQ_ENABLE_RESET; // RULE_12
			next_s.frameError = 1'b0;
			next_s.checkError = 1'b0;
			next_s.statusClear = 1'b1; // RULE_08
		end
		if (s.hardPulse) begin
			next_s.powerOnFlag = 1'b1;
			next_s.supplyOffCount = IACR_HARD_OFF_CYCLES; // RULE_09
		end else if (s.supplyOffCount != 8'd0) begin
			next_s.supplyOffCount = 8'(s.supplyOffCount - 8'd1);
		end

		next_s.fieldSupplyOn = ~next_s.control[IACR_CTL_FIELD_SUPPLY_OFF] & // RULE_06
			~next_s.hardPulse & (next_s.supplyOffCount == 8'd0); // RULE_09

		next_s.irq = (|(statusWord[12:8] & s.irqEnable[12:8])) | // RULE_11
			(|(riseSeen & s.irqEnable[IACR_STAT_RISE_LSB +: 4])) | // RULE_01
			(|(fallSeen & s.irqEnable[IACR_STAT_FALL_LSB +: 4])); // RULE_02
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s <= '0;
			s.csSync <= 2'b11;
			s.csPrev <= 1'b1;
			s.powerOnFlag <= 1'b1;
			s.fieldSupplyOn <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign spiMisoOut = s.shiftOut[23];
	// The output is let go one cycle after select ends, once the shift register is empty.
	assign spiMisoEnN = s.csPrev;
	assign irq = s.irq;

	always_comb begin
		ctl.frameCheckEnable = s.control[IACR_CTL_FRAME_CHECK_ENABLE]; // RULE_03
		ctl.sharedThresholdEnable = s.control[IACR_CTL_SHARED_THRESHOLD_ENABLE]; // RULE_04
		ctl.avgFilterClear = s.control[IACR_CTL_AVG_FILTER_CLEAR_LSB +: 4]; // RULE_05
		ctl.fieldSupplyOn = s.fieldSupplyOn;
		ctl.softResetPulse = s.softPulse;
		ctl.hardResetPulse = s.hardPulse;
	end

endmodule : iacr_control_regs

// ===== iacr_pkg.sv
package iacr_pkg;

	// Register addresses carried in the command byte of a serial frame.
	localparam logic [5:0] IACR_ADDR_PRODUCT_ID = 6'h00;
	localparam logic [5:0] IACR_ADDR_IRQ_STATUS = 6'h12;
	localparam logic [5:0] IACR_ADDR_IRQ_ENABLE = 6'h13;
	localparam logic [5:0] IACR_ADDR_CONTROL = 6'h14;

	// Device control register fields.
	localparam int unsigned IACR_CTL_FRAME_CHECK_ENABLE = 15;
	localparam int unsigned IACR_CTL_SHARED_THRESHOLD_ENABLE = 14;
	localparam int unsigned IACR_CTL_AVG_FILTER_CLEAR_LSB = 4;
	localparam int unsigned IACR_CTL_FIELD_SUPPLY_OFF = 3;
	localparam int unsigned IACR_CTL_POWER_ON_FLAG_CLEAR = 2;
	localparam int unsigned IACR_CTL_SOFT_RESET_REQUEST = 1;
	localparam int unsigned IACR_CTL_HARD_RESET_REQUEST = 0;
	localparam logic [15:0] IACR_CTL_STORED_MASK = 16'hc0f8;
	localparam logic [15:0] IACR_CTL_RESET = 16'h0000;

	// Interrupt enable and status layout.
	localparam logic [15:0] IACR_IRQ_ENABLE_MASK = 16'h1fff;
	localparam logic [15:0] IACR_IRQ_ENABLE_RESET = 16'h0000;
	localparam int unsigned IACR_STAT_FRAME_ERROR = 9;
	localparam int unsigned IACR_STAT_CHECK_ERROR = 8;
	localparam int unsigned IACR_STAT_RISE_LSB = 4;
	localparam int unsigned IACR_STAT_FALL_LSB = 0;

	// Product identification word: power-on flag plus an arbitrary code.
	localparam int unsigned IACR_ID_POWER_ON_FLAG = 7;
	localparam logic [6:0] IACR_ID_CODE = 7'h2a;

	// Serial frame geometry and check code.
	localparam logic [5:0] IACR_FRAME_BITS_PLAIN = 6'd24;
	localparam logic [5:0] IACR_FRAME_BITS_CHECKED = 6'd32;
	localparam logic [5:0] IACR_CMD_BITS = 6'd8;
	localparam logic [7:0] IACR_CHECK_POLY = 8'h07;

	// Time the field supply stays off after a hard reset request.
	localparam int unsigned IACR_CLOCK_MHZ = 250;
	localparam int unsigned IACR_HARD_OFF_TIME_NS = 1000;
	localparam logic [7:0] IACR_HARD_OFF_CYCLES =
		8'((IACR_HARD_OFF_TIME_NS * IACR_CLOCK_MHZ + 999) / 1000);

	typedef struct packed {
		logic frameCheckEnable;
		logic sharedThresholdEnable;
		logic [3:0] avgFilterClear;
		logic fieldSupplyOn;
		logic softResetPulse;
		logic hardResetPulse;
	} iacr_ctl_s;

	typedef struct packed {
		logic primed;
		logic [3:0] compPrev;
		logic [3:0] riseSeen;
		logic [3:0] fallSeen;
	} iacr_edge_s;

	typedef struct packed {
		logic [1:0] csSync;
		logic csPrev;
		logic [2:0] sclkSync;
		logic [1:0] mosiSync;
		logic [5:0] bitCount;
		logic [31:0] shiftIn;
		logic [23:0] shiftOut;
		logic [15:0] control;
		logic [15:0] irqEnable;
		logic powerOnFlag;
		logic frameError;
		logic checkError;
		logic softPulse;
		logic hardPulse;
		logic [7:0] supplyOffCount;
		logic fieldSupplyOn;
		logic statusClear;
		logic irq;
	} iacr_main_s;

	function automatic logic [7:0] iacr_check8(input logic [23:0] d);
		logic [7:0] c;
		logic fb;
		c = 8'h00;
		for (int i = 23; i >= 0; i--) begin
			fb = c[7] ^ d[i];
			c = {c[6:0], 1'b0};
			if (fb) begin
				c = c ^ IACR_CHECK_POLY;
			end
		end
		return c;
	endfunction : iacr_check8

endpackage : iacr_pkg

// ===== iacr_edge_flags.sv
`timescale 1ns/100ps
module iacr_edge_flags
	import iacr_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [3:0] comparatorOut,
	input wire logic clearAll,
	output logic [3:0] riseSeen,
	output logic [3:0] fallSeen
);

	iacr_edge_s s;
	iacr_edge_s next_s;

	always_comb begin
		next_s = s;
		next_s.primed = 1'b1;
		next_s.compPrev = comparatorOut;
		if (clearAll) begin
			next_s.riseSeen = 4'h0;
			next_s.fallSeen = 4'h0;
		end
		// The first cycle only learns the levels, so a high input at start is no edge.
		// Setting after clearing lets an edge in the clearing cycle survive.
		if (s.primed) begin
			next_s.riseSeen = next_s.riseSeen | (comparatorOut & ~s.compPrev);
			next_s.fallSeen = next_s.fallSeen | (~comparatorOut & s.compPrev); // RULE_10
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign riseSeen = s.riseSeen;
	assign fallSeen = s.fallSeen;

endmodule : iacr_edge_flags

// ===== iacr_props.sv
`timescale 1ns/100ps
module iacr_props
	import iacr_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic spiSclk,
	input wire logic spiCsN,
	input wire logic spiMosi,
	input wire logic spiMisoOut,
	input wire logic spiMisoEnN,
	input wire logic [3:0] comparatorOut,
	input wire iacr_ctl_s ctl,
	input wire logic irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	property p_pulse; ctl.softResetPulse || ctl.hardResetPulse |=> !ctl[1:0]; endproperty
	a_pulse: assert property (p_pulse) else $error("reset pulse too long");
	property p_soft; ctl.softResetPulse |-> ##3 ctl[8:3] == 6'h00; endproperty
	a_soft: assert property (p_soft) else $error("soft reset kept fields");
	property p_hard; ctl.hardResetPulse |-> ##2 !ctl.fieldSupplyOn [*8]; endproperty
	a_hard: assert property (p_hard) else $error("supply on after hard reset");
	property p_hold; !spiCsN && $past(spiCsN, 6) == 1'b0 |-> $stable(ctl[8:3]); endproperty
	a_hold: assert property (p_hold) else $error("control moved inside frame");
	property p_idle; spiMisoEnN |-> !spiMisoOut; endproperty
	a_idle: assert property (p_idle) else $error("data out while released");
	property p_en; spiCsN [*4] |=> spiMisoEnN; endproperty
	a_en: assert property (p_en) else $error("driving while deselected");
	property p_rst; $rose(reset_n) |-> ctl == 9'h004 && !irq; endproperty
	a_rst: assert property (p_rst) else $error("bad reset state");
	property p_irq; ctl.softResetPulse |-> ##4 !irq; endproperty
	a_irq: assert property (p_irq) else $error("interrupt without enable");
endmodule : iacr_props
bind iacr_control_regs iacr_props iacr_props_inst (.clock(clock), .reset_n(reset_n),
	.spiSclk(spiSclk), .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMisoOut(spiMisoOut),
	.spiMisoEnN(spiMisoEnN), .comparatorOut(comparatorOut), .ctl(ctl), .irq(irq));

// ===== iacr_host.sv
`timescale 1ns/100ps
module iacr_host (
	input wire logic clock,
	input wire logic misoOut,
	input wire logic misoEnN,
	output logic sclk,
	output logic csN,
	output logic mosi
);
	logic last = 1'b0;
	initial begin
		sclk = 1'b0;
		csN = 1'b1;
		mosi = 1'b0;
	end
	function automatic logic [7:0] crc(input logic [23:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 23; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
		end
		return c;
	endfunction : crc
	// A released data line shows the inverse of its last level.
	task automatic xfer(input logic [23:0] f, input logic chk, input logic bad,
		output logic [15:0] rx);
		logic [31:0] s;
		logic [31:0] r;
		s = chk ? {f, crc(f) ^ {7'h00, bad}} : {f, 8'h00};
		r = '0;
		@(posedge clock);
		csN <= 1'b0;
		for (int i = 31; i >= (chk ? 0 : 8); i--) begin
			@(posedge clock);
			sclk <= 1'b0;
			mosi <= s[i];
			repeat (5) @(posedge clock);
			@(negedge clock);
			last = misoEnN ? ~last : misoOut;
			r = {r[30:0], last};
			@(posedge clock);
			sclk <= 1'b1;
			repeat (4) @(posedge clock);
		end
		sclk <= 1'b0;
		mosi <= ~s[chk ? 0 : 8];
		repeat (4) @(posedge clock);
		csN <= 1'b1;
		repeat (10) @(posedge clock);
		@(negedge clock);
		rx = chk ? r[23:8] : r[15:0];
	endtask : xfer
endmodule : iacr_host

// ===== iacr_control_regs_tb.sv
`timescale 1ns/100ps
`define CK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
	$display("wrong value at %0t got %h expected %h", $time, (a), (b)); end end
module iacr_control_regs_tb
	import iacr_pkg::*;
;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic sclk, csN, mosi, misoOut, misoEnN, irq;
	logic [3:0] comp = 4'h0;
	logic chk = 1'b0;
	iacr_ctl_s ctl;
	int n_fail = 0;
	int checked = 0;
	int cycles = 0;
	logic [3:0] softCount;
	logic [3:0] hardCount;
	iacr_control_regs iacr_control_regs_inst (.clock(clock), .reset_n(reset_n),
		.spiSclk(sclk), .spiCsN(csN), .spiMosi(mosi), .spiMisoOut(misoOut),
		.spiMisoEnN(misoEnN), .comparatorOut(comp), .ctl(ctl), .irq(irq));
	iacr_host iacr_host_inst (.clock(clock), .misoOut(misoOut), .misoEnN(misoEnN),
		.sclk(sclk), .csN(csN), .mosi(mosi));
	initial begin
		forever #2 clock = ~clock;
	end
	task end_sim;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_sim
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			softCount <= 4'h0;
			hardCount <= 4'h0;
		end else begin
			softCount <= softCount + {3'h0, ctl.softResetPulse};
			hardCount <= hardCount + {3'h0, ctl.hardResetPulse};
		end
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			end_sim();
		end
	end
	task automatic wr(input logic [5:0] a, input logic [15:0] d, input logic bad);
		logic [15:0] x;
		iacr_host_inst.xfer({a, 2'b10, d}, chk, bad, x);
	endtask : wr
	task automatic rdc(input logic [5:0] a, input logic [15:0] e);
		logic [15:0] x;
		iacr_host_inst.xfer({a, 2'b00, 16'h0000}, chk, 1'b0, x);
		`CK(x, e)
	endtask : rdc
	task automatic step(input logic [3:0] c, input logic e);
		@(posedge clock);
		comp <= c;
		repeat (4) @(posedge clock);
		@(negedge clock);
		`CK(irq, e)
	endtask : step
	task t_reset;
		rdc(IACR_ADDR_PRODUCT_ID, {9'h001, IACR_ID_CODE});
		rdc(IACR_ADDR_CONTROL, 16'h0000);
		rdc(IACR_ADDR_IRQ_ENABLE, 16'h0000);
		`CK(ctl, 9'h004)
		$display("test reset done");
	endtask : t_reset
	task t_ctl;
		wr(IACR_ADDR_CONTROL, 16'hfff8, 1'b0);
		`CK(ctl, 9'h1f8)
		`CK(ctl.fieldSupplyOn, 1'b0)
		wr(IACR_ADDR_CONTROL, 16'h0000, 1'b0);
		chk = 1'b1;
		rdc(IACR_ADDR_CONTROL, IACR_CTL_STORED_MASK);
		wr(IACR_ADDR_CONTROL, 16'h0000, 1'b1);
		rdc(IACR_ADDR_CONTROL, 16'hc0f8);
		wr(IACR_ADDR_CONTROL, 16'h4000, 1'b0);
		chk = 1'b0;
		rdc(IACR_ADDR_CONTROL, 16'h4000);
		`CK(ctl, 9'h084)
		rdc(IACR_ADDR_IRQ_STATUS, 16'h0300);
		$display("test control done");
	endtask : t_ctl
	task t_irq;
		wr(IACR_ADDR_IRQ_ENABLE, 16'h0011, 1'b0);
		rdc(IACR_ADDR_IRQ_ENABLE, 16'h0011);
		step(4'h1, 1'b1);
		rdc(IACR_ADDR_IRQ_STATUS, 16'h0010);
		step(4'hf, 1'b0);
		step(4'h1, 1'b0);
		step(4'h0, 1'b1);
		rdc(IACR_ADDR_IRQ_STATUS, 16'h00ef);
		step(4'h0, 1'b0);
		$display("test interrupt done");
	endtask : t_irq
	task t_rst;
		wr(IACR_ADDR_CONTROL, 16'h0004, 1'b0);
		rdc(IACR_ADDR_PRODUCT_ID, {9'h000, IACR_ID_CODE});
		wr(IACR_ADDR_CONTROL, 16'h4002, 1'b0);
		`CK(softCount, 4'h1)
		rdc(IACR_ADDR_CONTROL, 16'h0000);
		rdc(IACR_ADDR_IRQ_ENABLE, 16'h0000);
		wr(IACR_ADDR_CONTROL, 16'h0001, 1'b0);
		`CK(ctl.fieldSupplyOn, 1'b0)
		`CK(hardCount, 4'h1)
		rdc(IACR_ADDR_PRODUCT_ID, {9'h001, IACR_ID_CODE});
		repeat (300) @(posedge clock);
		@(negedge clock);
		`CK(ctl, 9'h004)
		$display("test resets done");
	endtask : t_rst
	initial begin
		repeat (3) @(posedge clock);
		reset_n <= 1'b1;
		repeat (4) @(posedge clock);
		t_reset();
		t_ctl();
		t_irq();
		t_rst();
		end_sim();
	end
endmodule : iacr_control_regs_tb
